// [design/sac_pkg.sv]
package sac_pkg;

  // ------------------------------------------------------------
  // data and code range
  // ------------------------------------------------------------
  localparam int          DATA_W     = 13;
  localparam int          OFFS_W     = 8;
  localparam int          GAIN_W     = 6;
  localparam int          GAIN_SHIFT = 9;
  localparam logic [12:0] CODE_MAX   = 13'h0FFF;
  localparam logic [12:0] CODE_MIN   = 13'h1000;
  localparam logic [12:0] TEST_MASK  = 13'h006C;

  // ------------------------------------------------------------
  // sequence timing in converter clock periods
  // ------------------------------------------------------------
  localparam int          CNT_W      = 11;
  localparam logic [10:0] NULL_TICKS = 11'h01A;
  localparam logic [10:0] ACQ_TICKS  = 11'h007;
  localparam logic [10:0] CAL_TICKS  = 11'h574;
  localparam logic [3:0]  SAR_STEPS  = 4'hD;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STATUS   = 8'h04;
  localparam logic [7:0]  REG_RESULT   = 8'h08;
  localparam logic [7:0]  REG_IRQ_STS  = 8'h0C;
  localparam logic [7:0]  REG_IRQ_MASK = 8'h10;
  localparam logic [7:0]  REG_CORR     = 8'h14;
  localparam int          CTRL_CAL_BIT  = 0;
  localparam int          CTRL_NULL_BIT = 1;
  localparam logic        CTRL_NULL_RST = 1'h0;
  localparam int          IRQ_W      = 3;
  localparam int          IRQ_DONE   = 0;
  localparam int          IRQ_CAL    = 1;
  localparam int          IRQ_ABORT  = 2;
  localparam logic [2:0]  IRQ_RST    = 3'h0;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ARMED, ST_NULL, ST_ACQ, ST_CONV, ST_CAL
  } sac_state_t;

  typedef enum logic [2:0] {
    SEL_CTRL, SEL_STATUS, SEL_RESULT, SEL_IRQ_STS, SEL_IRQ_MASK, SEL_CORR, SEL_NONE
  } sac_sel_t;

endpackage

// [design/sac_sar_core.sv]
module sac_sar_core (
  // clock and reset
  input  wire logic                             clk,
  input  wire logic                             rst_n,
  // control
  input  wire logic                             start,
  input  wire logic                             tick,
  // held input and stored corrections
  input  wire logic [sac_pkg::DATA_W-1:0]       sample,
  input  wire logic signed [sac_pkg::OFFS_W-1:0] offset,
  input  wire logic signed [sac_pkg::GAIN_W-1:0] gain,
  // status and result
  output logic                                  busy,
  output logic                                  done,
  output logic [sac_pkg::DATA_W-1:0]            result
);

  // ------------------------------------------------------------
  // correction of the held sample
  // ------------------------------------------------------------
  logic signed [15:0] v_w;
  logic signed [21:0] prod_w;
  logic signed [15:0] adj_w;
  logic [12:0]        sat_w;

  assign v_w    = 16'(signed'(sample)) - 16'(offset);
  assign prod_w = 22'(v_w) * 22'(gain);
  assign adj_w  = v_w + 16'(prod_w >>> sac_pkg::GAIN_SHIFT);
  assign sat_w  = (adj_w > 16'sd4095)  ? sac_pkg::CODE_MAX :
                  (adj_w < -16'sd4096) ? sac_pkg::CODE_MIN : adj_w[12:0];

  // ------------------------------------------------------------
  // successive approximation: sign first, then twelve bits
  // ------------------------------------------------------------
  logic [11:0] mag_q;
  logic        sign_q;
  logic [11:0] acc_q;
  logic [11:0] mask_q;
  logic [3:0]  step_q;
  logic        busy_q;
  logic        done_q;
  logic [11:0] trial_w;

  assign trial_w = acc_q | mask_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mag_q  <= 12'h000;
      sign_q <= 1'h0;
      acc_q  <= 12'h000;
      mask_q <= 12'h000;
      step_q <= 4'h0;
      busy_q <= 1'h0;
      done_q <= 1'h0;
    end else begin
      done_q <= 1'h0;
      if (start) begin
        mag_q  <= sat_w[11:0];
        sign_q <= sat_w[12];
        acc_q  <= 12'h000;
        mask_q <= 12'h800;
        step_q <= sac_pkg::SAR_STEPS;
        busy_q <= 1'h1;
      end else if (busy_q && tick) begin
        step_q <= step_q - 4'h1;
        if (step_q != sac_pkg::SAR_STEPS) begin
          if (mag_q >= trial_w) begin
            acc_q <= trial_w;
          end
          mask_q <= mask_q >> 1;
        end
        if (step_q == 4'h1) begin
          busy_q <= 1'h0;
          done_q <= 1'h1;
        end
      end
    end
  end

  assign busy   = busy_q;
  assign done   = done_q;
  assign result = {sign_q, acc_q};

endmodule

// [design/sac_sequencer.sv]
module sac_sequencer (
  // clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // axi4-lite write address
  input  wire logic [sac_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // axi4-lite read address
  input  wire logic [sac_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // host control strobes and converter clock
  input  wire logic                        device_select_n,
  input  wire logic                        write_strobe_n,
  input  wire logic                        read_strobe_n,
  input  wire logic                        calibrate_request_n,
  input  wire logic                        offset_null_request_n,
  input  wire logic                        conv_clk,
  // front-end stand-ins: digitised input, comparator offset, gain error
  input  wire logic [sac_pkg::DATA_W-1:0]  sample_code,
  input  wire logic [sac_pkg::OFFS_W-1:0]  comp_offset,
  input  wire logic [sac_pkg::GAIN_W-1:0]  gain_error,
  // result bus, data and drive enable per pin
  output logic [sac_pkg::DATA_W-1:0]       result_bus_o,
  output logic [sac_pkg::DATA_W-1:0]       result_bus_oe,
  // status pins
  output logic                             conversion_active_n,
  output logic                             result_ready_n,
  output logic                             test_mode,
  output logic                             irq
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  localparam int NSYNC = 6;

  logic [NSYNC-1:0] pin_w;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;

  assign pin_w = {conv_clk, offset_null_request_n, calibrate_request_n,
                  read_strobe_n, write_strobe_n, device_select_n};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync1_q[gi] <= 1'h1;
          sync2_q[gi] <= 1'h1;
        end else begin
          sync1_q[gi] <= pin_w[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  // slow front-end words are only sampled at hold, offset-null end or calibration end
  logic [sac_pkg::DATA_W-1:0] samp1_q;
  logic [sac_pkg::DATA_W-1:0] samp2_q;
  logic [sac_pkg::OFFS_W-1:0] offs1_q;
  logic [sac_pkg::OFFS_W-1:0] offs2_q;
  logic [sac_pkg::GAIN_W-1:0] gain1_q;
  logic [sac_pkg::GAIN_W-1:0] gain2_q;

  always_ff @(posedge aclk) begin
    samp1_q <= sample_code;
    samp2_q <= samp1_q;
    offs1_q <= comp_offset;
    offs2_q <= offs1_q;
    gain1_q <= gain_error;
    gain2_q <= gain1_q;
  end

  // ------------------------------------------------------------
  // strobe decode
  // ------------------------------------------------------------
  logic cs_w;
  logic wr_w;
  logic rd_w;
  logic cal_w;
  logic nul_w;
  logic ck_w;
  logic wr_prev_q;
  logic cal_prev_q;
  logic ck_prev_q;

  assign cs_w  = sync2_q[0];
  assign wr_w  = sync2_q[1];
  assign rd_w  = sync2_q[2];
  assign cal_w = sync2_q[3];
  assign nul_w = sync2_q[4];
  assign ck_w  = sync2_q[5];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_prev_q  <= 1'h1;
      cal_prev_q <= 1'h1;
      ck_prev_q  <= 1'h1;
    end else begin
      wr_prev_q  <= wr_w;
      cal_prev_q <= cal_w;
      ck_prev_q  <= ck_w;
    end
  end

  logic tick_w;
  logic wr_fall_w;
  logic wr_rise_w;
  logic cal_fall_w;
  logic read_w;
  logic test_w;

  assign tick_w     = ck_w & ~ck_prev_q;
  assign wr_fall_w  = ~cs_w & wr_prev_q & ~wr_w;
  assign wr_rise_w  = ~cs_w & ~wr_prev_q & wr_w & rd_w & cal_w;
  assign cal_fall_w = cs_w & cal_prev_q & ~cal_w;
  assign read_w     = ~cs_w & ~rd_w & wr_w & cal_w;
  assign test_w     = ~cs_w & ~cal_w & rd_w;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  sac_pkg::sac_state_t state_q;
  sac_pkg::sac_state_t state_d;
  logic [sac_pkg::CNT_W-1:0] cnt_q;
  logic [sac_pkg::CNT_W-1:0] cnt_d;
  logic ctrl_null_q;
  logic sw_cal_q;
  logic use_null_w;
  logic cnt_end_w;
  logic cal_go_w;
  logic abort_w;
  logic hold_w;
  logic conv_done_w;
  logic cal_end_w;
  logic core_busy_w;
  logic [sac_pkg::DATA_W-1:0] core_res_w;
  logic signed [sac_pkg::OFFS_W-1:0] off_corr_q;
  logic signed [sac_pkg::GAIN_W-1:0] gain_corr_q;

  assign use_null_w = ~nul_w | ctrl_null_q;
  assign cnt_end_w  = tick_w & (cnt_q == 11'h001);
  assign cal_go_w   = (cal_fall_w | sw_cal_q) & (state_q != sac_pkg::ST_CAL);
  assign abort_w    = wr_fall_w & ~cal_go_w &
                      ((state_q == sac_pkg::ST_NULL) | (state_q == sac_pkg::ST_ACQ) |
                       (state_q == sac_pkg::ST_CONV));
  assign hold_w     = (state_q == sac_pkg::ST_ACQ) & cnt_end_w;
  assign cal_end_w  = (state_q == sac_pkg::ST_CAL) & cnt_end_w;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    if (state_q == sac_pkg::ST_CAL) begin
      // nothing may interrupt a calibration
      if (cnt_end_w) begin
        state_d = sac_pkg::ST_IDLE;
      end else if (tick_w) begin
        cnt_d = cnt_q - 11'h001;
      end
    end else if (cal_go_w) begin
      state_d = sac_pkg::ST_CAL;
      cnt_d   = sac_pkg::CAL_TICKS;
    end else if (wr_fall_w) begin
      state_d = sac_pkg::ST_ARMED;
    end else begin
      case (state_q)
        sac_pkg::ST_ARMED: begin
          if (wr_rise_w) begin
            state_d = use_null_w ? sac_pkg::ST_NULL : sac_pkg::ST_ACQ;
            cnt_d   = use_null_w ? sac_pkg::NULL_TICKS : sac_pkg::ACQ_TICKS;
          end
        end
        sac_pkg::ST_NULL: begin
          if (cnt_end_w) begin
            state_d = sac_pkg::ST_ACQ;
            cnt_d   = sac_pkg::ACQ_TICKS;
          end else if (tick_w) begin
            cnt_d = cnt_q - 11'h001;
          end
        end
        sac_pkg::ST_ACQ: begin
          if (cnt_end_w) begin
            state_d = sac_pkg::ST_CONV;
          end else if (tick_w) begin
            cnt_d = cnt_q - 11'h001;
          end
        end
        sac_pkg::ST_CONV: begin
          if (conv_done_w) begin
            state_d = sac_pkg::ST_IDLE;
          end
        end
        default: begin
          state_d = state_q;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= sac_pkg::ST_CAL;
      cnt_q   <= sac_pkg::CAL_TICKS;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  sac_sar_core u_core (
    .clk    (aclk),
    .rst_n  (aresetn & ~wr_fall_w),
    .start  (hold_w),
    .tick   (tick_w),
    .sample (samp2_q),
    .offset (off_corr_q),
    .gain   (gain_corr_q),
    .busy   (core_busy_w),
    .done   (conv_done_w),
    .result (core_res_w)
  );

  // ------------------------------------------------------------
  // correction store, result latch and flags
  // ------------------------------------------------------------
  logic [sac_pkg::DATA_W-1:0] res_q;
  logic first_cal_q;
  logic coarse_q;
  logic corrupt_q;
  logic null_end_w;
  logic start_w;

  assign null_end_w = (state_q == sac_pkg::ST_NULL) & cnt_end_w;
  assign start_w    = (state_q == sac_pkg::ST_ARMED) & wr_rise_w & ~cal_go_w;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      off_corr_q  <= '0;
      gain_corr_q <= '0;
      res_q       <= '0;
      first_cal_q <= 1'h1;
      coarse_q    <= 1'h1;
      corrupt_q   <= 1'h0;
    end else begin
      if (cal_end_w) begin
        off_corr_q  <= offs2_q;
        gain_corr_q <= gain2_q;
        first_cal_q <= 1'h0;
        coarse_q    <= first_cal_q;
      end else if (null_end_w) begin
        off_corr_q <= offs2_q;
      end
      if (conv_done_w) begin
        res_q <= core_res_w;
      end
      // a restart during sampling or conversion marks the corrections suspect
      if (abort_w && state_q != sac_pkg::ST_NULL) begin
        corrupt_q <= 1'h1;
      end else if (cal_end_w) begin
        corrupt_q <= 1'h0;
      end
    end
  end

  // ------------------------------------------------------------
  // pin outputs
  // ------------------------------------------------------------
  logic eoc_n_q;
  logic int_n_q;
  logic test_q;
  logic [sac_pkg::DATA_W-1:0] dout_q;
  logic [sac_pkg::DATA_W-1:0] doe_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eoc_n_q <= 1'h1;
      int_n_q <= 1'h1;
      test_q  <= 1'h0;
      dout_q  <= '0;
      doe_q   <= '0;
    end else begin
      eoc_n_q <= ~((state_d == sac_pkg::ST_CONV) | (state_d == sac_pkg::ST_CAL));
      if (conv_done_w) begin
        int_n_q <= 1'h0;
      end else if (read_w || start_w || cal_go_w) begin
        int_n_q <= 1'h1;
      end
      test_q <= test_w;
      dout_q <= res_q;
      doe_q  <= read_w ? {sac_pkg::DATA_W{1'b1}} :
                test_w ? sac_pkg::TEST_MASK : '0;
    end
  end

  assign conversion_active_n = eoc_n_q;
  assign result_ready_n      = int_n_q;
  assign test_mode           = test_q;
  assign result_bus_o        = dout_q;
  assign result_bus_oe       = doe_q;

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  function automatic sac_pkg::sac_sel_t reg_sel(input logic [sac_pkg::ADDR_W-1:0] a);
    case (a)
      sac_pkg::REG_CTRL:     reg_sel = sac_pkg::SEL_CTRL;
      sac_pkg::REG_STATUS:   reg_sel = sac_pkg::SEL_STATUS;
      sac_pkg::REG_RESULT:   reg_sel = sac_pkg::SEL_RESULT;
      sac_pkg::REG_IRQ_STS:  reg_sel = sac_pkg::SEL_IRQ_STS;
      sac_pkg::REG_IRQ_MASK: reg_sel = sac_pkg::SEL_IRQ_MASK;
      sac_pkg::REG_CORR:     reg_sel = sac_pkg::SEL_CORR;
      default:               reg_sel = sac_pkg::SEL_NONE;
    endcase
  endfunction

  logic aw_rdy_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic ar_rdy_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [sac_pkg::IRQ_W-1:0] irq_sts_q;
  logic [sac_pkg::IRQ_W-1:0] irq_mask_q;
  logic irq_q;

  sac_pkg::sac_sel_t wsel_w;
  sac_pkg::sac_sel_t rsel_w;
  logic wr_go_w;
  logic wr_do_w;
  logic rd_go_w;
  logic wr_lo_w;
  logic [sac_pkg::IRQ_W-1:0] ev_w;
  logic [sac_pkg::IRQ_W-1:0] w1c_w;
  logic [31:0] rmux_w;

  assign wsel_w  = reg_sel(s_axi_awaddr);
  assign rsel_w  = reg_sel(s_axi_araddr);
  assign wr_go_w = s_axi_awvalid & s_axi_wvalid & ~aw_rdy_q & ~bvalid_q;
  assign wr_do_w = aw_rdy_q;
  assign wr_lo_w = wr_do_w & s_axi_wstrb[0];
  assign rd_go_w = s_axi_arvalid & ~ar_rdy_q & ~rvalid_q;
  assign ev_w    = {abort_w, cal_end_w, conv_done_w};
  assign w1c_w   = (wr_lo_w && wsel_w == sac_pkg::SEL_IRQ_STS) ?
                   s_axi_wdata[sac_pkg::IRQ_W-1:0] : '0;

  assign rmux_w =
    (rsel_w == sac_pkg::SEL_CTRL)     ? {30'h0, ctrl_null_q, 1'h0} :
    (rsel_w == sac_pkg::SEL_STATUS)   ? {24'h0, coarse_q, corrupt_q, test_q,
                                         ~int_n_q, ~eoc_n_q, 3'(state_q)} :
    (rsel_w == sac_pkg::SEL_RESULT)   ? {{19{res_q[12]}}, res_q} :
    (rsel_w == sac_pkg::SEL_IRQ_STS)  ? {29'h0, irq_sts_q} :
    (rsel_w == sac_pkg::SEL_IRQ_MASK) ? {29'h0, irq_mask_q} :
    (rsel_w == sac_pkg::SEL_CORR)     ? {10'h0, 2'(gain_corr_q >>> 4), gain_corr_q,
                                         off_corr_q, 6'h0} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_rdy_q    <= 1'h0;
      bvalid_q    <= 1'h0;
      bresp_q     <= sac_pkg::RESP_OKAY;
      ctrl_null_q <= sac_pkg::CTRL_NULL_RST;
      sw_cal_q    <= 1'h0;
      irq_mask_q  <= sac_pkg::IRQ_RST;
    end else begin
      aw_rdy_q <= wr_go_w;
      sw_cal_q <= 1'h0;
      if (wr_do_w) begin
        bvalid_q <= 1'h1;
        bresp_q  <= (wsel_w == sac_pkg::SEL_NONE) ? sac_pkg::RESP_SLVERR : sac_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'h0;
      end
      if (wr_lo_w && wsel_w == sac_pkg::SEL_CTRL) begin
        ctrl_null_q <= s_axi_wdata[sac_pkg::CTRL_NULL_BIT];
        sw_cal_q    <= s_axi_wdata[sac_pkg::CTRL_CAL_BIT];
      end
      if (wr_lo_w && wsel_w == sac_pkg::SEL_IRQ_MASK) begin
        irq_mask_q <= s_axi_wdata[sac_pkg::IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_sts_q <= sac_pkg::IRQ_RST;
      irq_q     <= 1'h0;
      ar_rdy_q  <= 1'h0;
      rvalid_q  <= 1'h0;
      rresp_q   <= sac_pkg::RESP_OKAY;
      rdata_q   <= 32'h0;
    end else begin
      // a new event wins over a clear in the same cycle
      irq_sts_q <= (irq_sts_q & ~w1c_w) | ev_w;
      irq_q     <= |(irq_sts_q & irq_mask_q);
      ar_rdy_q  <= rd_go_w;
      if (ar_rdy_q) begin
        rvalid_q <= 1'h1;
        rdata_q  <= rmux_w;
        rresp_q  <= (rsel_w == sac_pkg::SEL_NONE) ? sac_pkg::RESP_SLVERR : sac_pkg::RESP_OKAY;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'h0;
      end
    end
  end

  assign s_axi_awready = aw_rdy_q;
  assign s_axi_wready  = aw_rdy_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ar_rdy_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign irq           = irq_q;

endmodule

// [dv/sac_checker.sv]
module sac_checker (
  // clock and reset
  input wire logic                        aclk,
  input wire logic                        aresetn,
  // host strobes
  input wire logic                        device_select_n,
  input wire logic                        write_strobe_n,
  input wire logic                        read_strobe_n,
  input wire logic                        calibrate_request_n,
  input wire logic                        offset_null_request_n,
  // status and result bus
  input wire logic [sac_pkg::DATA_W-1:0]  result_bus_oe,
  input wire logic                        conversion_active_n,
  input wire logic                        result_ready_n,
  input wire logic                        test_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [13:0] lo_q;
  wire go = !device_select_n && read_strobe_n && calibrate_request_n;
  // length of the current low spell of conversion_active_n
  always_ff @(posedge aclk) lo_q <= (!aresetn || conversion_active_n) ? 14'h0 : lo_q + 14'h1;
  property p_hold;
    $rose(write_strobe_n) && go && offset_null_request_n && conversion_active_n
      |-> ##[50:75] $fell(conversion_active_n);
  endproperty
  a_hold: assert property (p_hold) else $error("hold not in window");
  property p_null;
    $rose(write_strobe_n) && go && !offset_null_request_n && conversion_active_n
      |-> ##[255:290] $fell(conversion_active_n);
  endproperty
  a_null: assert property (p_null) else $error("offset-null hold not in window");
  property p_rdy;
    $rose(write_strobe_n) && go |-> ##[1:6] result_ready_n;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready stays low after start");
  property p_eoc;
    $fell(result_ready_n) |-> $rose(conversion_active_n);
  endproperty
  a_eoc: assert property (p_eoc) else $error("ready and active disagree");
  property p_lo_min;
    $fell(conversion_active_n) |-> !conversion_active_n [*8];
  endproperty
  a_lo_min: assert property (p_lo_min) else $error("active spell too short");
  property p_lo_max;
    lo_q < 14'h2C00;
  endproperty
  a_lo_max: assert property (p_lo_max) else $error("active spell too long");
  property p_test;
    (!device_select_n && !calibrate_request_n && read_strobe_n) [*5]
      |-> test_mode && result_bus_oe == 13'h006C;
  endproperty
  a_test: assert property (p_test) else $error("test mode drive wrong");
  property p_read;
    (!device_select_n && !read_strobe_n && write_strobe_n && calibrate_request_n) [*5]
      |-> result_bus_oe == 13'h1FFF && result_ready_n;
  endproperty
  a_read: assert property (p_read) else $error("read drive wrong");
  property p_off;
    device_select_n [*5] |-> result_bus_oe == 13'h0000;
  endproperty
  a_off: assert property (p_off) else $error("bus driven while deselected");
  c_done: cover property ($fell(result_ready_n));
  c_test: cover property (test_mode);
  c_cal: cover property (lo_q == 14'h2000);
endmodule

bind sac_sequencer sac_checker u_chk (.aclk, .aresetn, .device_select_n, .write_strobe_n,
  .read_strobe_n, .calibrate_request_n, .offset_null_request_n, .result_bus_oe,
  .conversion_active_n, .result_ready_n, .test_mode);

// [dv/sac_host_model.sv]
module sac_host_model (
  // clock
  input wire logic aclk,
  // host strobes
  output logic     device_select_n,
  output logic     write_strobe_n,
  output logic     read_strobe_n,
  output logic     calibrate_request_n,
  output logic     offset_null_request_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {device_select_n, write_strobe_n, read_strobe_n, calibrate_request_n,
    offset_null_request_n} = 5'h1F;
  // strobes change just after an edge, then stand for n edges
  task automatic put(input logic [4:0] v, input int n);
    @(posedge aclk);
    {device_select_n, write_strobe_n, read_strobe_n, calibrate_request_n,
      offset_null_request_n} <= v;
    repeat (n) @(posedge aclk);
  endtask
endmodule

// [dv/tb_sar_adc_control_sequencer.sv]
module tb_sar_adc_control_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 1'b0, aresetn = 1'b0, conv_clk = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, comp_offset = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [12:0] sample_code = 13'h1000;
  logic [5:0] gain_error = 6'h00;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [12:0] result_bus_o, result_bus_oe;
  wire conversion_active_n, result_ready_n, test_mode, device_select_n, write_strobe_n;
  wire read_strobe_n, calibrate_request_n, offset_null_request_n;
  int num_errors = 0, n_tests = 0, c, d;
  sac_sequencer u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .device_select_n, .write_strobe_n, .read_strobe_n,
    .calibrate_request_n, .offset_null_request_n, .conv_clk, .sample_code, .comp_offset,
    .gain_error, .result_bus_o, .result_bus_oe, .conversion_active_n, .result_ready_n,
    .test_mode, .irq);
  sac_host_model u_host (.aclk, .device_select_n, .write_strobe_n, .read_strobe_n,
    .calibrate_request_n, .offset_null_request_n);
  initial forever #12.5 aclk = ~aclk;
  // converter clock at an eighth of aclk, phase unrelated
  initial begin
    #7;
    forever #100 conv_clk = ~conv_clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic close_out;
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    chk(32'(s_axi_wready), 32'h1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(r));
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(r));
  endtask
  // edges until conversion_active_n shows v
  task automatic wa(input logic v);
    c = 0;
    do begin
      @(posedge aclk);
      c++;
    end while (conversion_active_n !== v);
  endtask
  task automatic conv(input logic az);
    u_host.put({4'b0011, az}, 12);
    u_host.put({4'b0111, az}, 0);
    wa(1'b0);
  endtask
  task automatic wait_rdy;
    while (result_ready_n !== 1'b0) @(posedge aclk);
  endtask
  initial begin
    repeat (40000) @(posedge aclk);
    num_errors++;
    close_out;
  end
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    wa(1'b0);
    chk(32'(c <= 4), 32'h1);
    wa(1'b1);
    chk(32'(c inside {[11150:11200]}), 32'h1);
    axr(8'h04, 32'h80, 2'h0);
    axw(8'h10, 32'h7, 2'h0);
    axw(8'h0C, 32'h7, 2'h0);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0);
    comp_offset <= 8'h10;
    axw(8'h00, 32'h1, 2'h0);
    wa(1'b0);
    wa(1'b1);
    chk(32'(c inside {[11150:11200]}), 32'h1);
    repeat (3) @(posedge aclk);
    chk(32'(irq), 32'h1);
    axr(8'h0C, 32'h2, 2'h0);
    axw(8'h0C, 32'h2, 2'h0);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0);
    axr(8'h04, 32'h0, 2'h0);
    axr(8'h14, 32'h400, 2'h0);
    conv(1'b1);
    d = c;
    chk(32'(c inside {[50:75]}), 32'h1);
    wait_rdy;
    chk(32'(conversion_active_n), 32'h1);
    axr(8'h08, 32'hFFFFF000, 2'h0);
    u_host.put(5'b01011, 8);
    chk(32'(result_bus_oe), 32'h1FFF);
    chk(32'(result_bus_o), 32'h1000);
    chk(32'(result_ready_n), 32'h1);
    u_host.put(5'h1F, 8);
    chk(32'(result_bus_oe), 32'h0);
    sample_code <= 13'h0FFF;
    conv(1'b0);
    chk(32'((c - d) inside {[200:216]}), 32'h1);
    wait_rdy;
    axr(8'h08, 32'h00000FEF, 2'h0);
    conv(1'b1);
    repeat (10) @(posedge aclk);
    u_host.put(5'b00111, 12);
    chk(32'(conversion_active_n), 32'h1);
    axr(8'h04, 32'h41, 2'h0);
    u_host.put(5'b10111, 8);
    u_host.put(5'h1F, 12);
    u_host.put(5'b11101, 12);
    u_host.put(5'h1F, 8);
    u_host.put(5'b00111, 12);
    u_host.put(5'b01111, 12);
    u_host.put(5'h1F, 8);
    chk(32'(conversion_active_n), 32'h0);
    wa(1'b1);
    axr(8'h04, 32'h0, 2'h0);
    u_host.put(5'b01101, 8);
    chk(32'(test_mode), 32'h1);
    chk(32'(result_bus_oe), 32'h6C);
    u_host.put(5'b01111, 8);
    u_host.put(5'h1F, 8);
    chk(32'(test_mode), 32'h0);
    axr(8'h40, 32'h0, 2'h2);
    axw(8'h40, 32'h1, 2'h2);
    close_out;
  end
endmodule
